// ===== verilog/xcv_transceiver.sv
`timescale 1ns/1ps
module xcv_transceiver #(
  parameter int DATA_W    = xcv_pkg::XCV_DATA_W,
  parameter int BUF_DEPTH = xcv_pkg::XCV_BUF_DEPTH
) (
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_ce,
  input  wire logic              i_a_to_b_drive_enable,
  input  wire logic              i_a_to_b_transparent_ctl,
  input  wire logic              i_a_to_b_capture_clk,
  input  wire logic              i_b_to_a_drive_enable_n,
  input  wire logic              i_b_to_a_transparent_ctl,
  input  wire logic              i_b_to_a_capture_clk,
  input  wire xcv_pkg::xcv_word_t i_a,
  output xcv_pkg::xcv_word_t     o_a,
  output logic                   o_a_oe,
  input  wire xcv_pkg::xcv_word_t i_b,
  output xcv_pkg::xcv_word_t     o_b,
  output logic                   o_b_oe,
  input  wire logic              i_a_accept,
  input  wire logic              i_b_accept
);
  import xcv_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    xcv_pins_s [XCV_DIRS-1:0] s1;
    xcv_pins_s [XCV_DIRS-1:0] s2;
    xcv_pins_s [XCV_DIRS-1:0] s3;
    xcv_pins_s [XCV_DIRS-1:0] flt;
    xcv_word_t [XCV_DIRS-1:0] store;
    xcv_word_t [XCV_DIRS-1:0] sent;
    xcv_word_t [XCV_DIRS-1:0] out;
    logic      [XCV_DIRS-1:0] oe;
  } xcv_state_s;

  xcv_state_s                q;
  xcv_state_s                next_q;
  xcv_pins_s  [XCV_DIRS-1:0] raw;
  logic       [XCV_DIRS-1:0] push_valid;
  logic       [XCV_DIRS-1:0] push_ready;
  logic       [XCV_DIRS-1:0] pop_valid;
  logic       [XCV_DIRS-1:0] pop_ready;
  xcv_word_t  [XCV_DIRS-1:0] pop_data;

  ////////////////////////////////////////////////////////////////////////////
  // pin gathering, drive enables brought to active high
  always_comb begin
    raw[XCV_AB].drive       = i_a_to_b_drive_enable;
    raw[XCV_AB].transparent = i_a_to_b_transparent_ctl;
    raw[XCV_AB].capture_clk = i_a_to_b_capture_clk;
    raw[XCV_AB].data        = i_a;
    raw[XCV_BA].drive       = ~i_b_to_a_drive_enable_n;
    raw[XCV_BA].transparent = i_b_to_a_transparent_ctl;
    raw[XCV_BA].capture_clk = i_b_to_a_capture_clk;
    raw[XCV_BA].data        = i_b;
  end

  assign pop_ready[XCV_AB] = i_b_accept;
  assign pop_ready[XCV_BA] = i_a_accept;

  ////////////////////////////////////////////////////////////////////////////
  // per-direction path
  always_comb begin
    logic [XCV_PINS_W-1:0] agree;
    logic [XCV_PINS_W-1:0] filt;
    xcv_pins_s             nf;
    logic                  rise;
    logic                  load;
    agree  = '0;
    filt   = '0;
    nf     = XCV_PINS_RST;
    rise   = 1'b0;
    load   = 1'b0;
    next_q = q;
    for (int d = 0; d < XCV_DIRS; d++) begin
      next_q.s1[d] = raw[d];
      next_q.s2[d] = q.s1[d];
      next_q.s3[d] = q.s2[d];
      // a bit changes once stages two and three agree
      agree = ~(q.s2[d] ^ q.s3[d]);
      filt  = (q.s3[d] & agree) | (q.flt[d] & ~agree);
      nf    = xcv_pins_s'(filt);
      next_q.flt[d] = nf;
      rise  = nf.capture_clk & ~q.flt[d].capture_clk;
      // transparent follows, else only a rising edge loads
      load  = nf.transparent | rise;
      if (nf.transparent) begin
        next_q.store[d] = nf.data;
      end else if (rise) begin
        next_q.store[d] = nf.data;
      end else begin
        next_q.store[d] = q.store[d];
      end
      if (!load) begin
        next_q.store[d] = q.store[d];
      end
      // hand the stored word to the buffer once
      if (push_valid[d] && push_ready[d]) begin
        next_q.sent[d] = q.store[d];
      end
      if (pop_valid[d] && pop_ready[d]) begin
        next_q.out[d] = pop_data[d];
      end
      next_q.oe[d] = nf.drive;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // two-entry buffer per direction
  for (genvar g = 0; g < XCV_DIRS; g++) begin : g_dir
    assign push_valid[g] = (q.store[g] != q.sent[g]);
    xcv_buf #(
      .WIDTH (DATA_W),
      .DEPTH (BUF_DEPTH)
    ) u_buf (
      .i_sys_clk   (i_sys_clk),
      .i_rst_n     (i_rst_n),
      .i_ce        (i_ce),
      .i_in_valid  (push_valid[g]),
      .o_in_ready  (push_ready[g]),
      .i_in_data   (q.store[g]),
      .o_out_valid (pop_valid[g]),
      .i_out_ready (pop_ready[g]),
      .o_out_data  (pop_data[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      q <= '0;
    end else if (i_ce) begin
      q <= next_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins
  assign o_b    = q.out[XCV_AB];
  assign o_b_oe = q.oe[XCV_AB];
  assign o_a    = q.out[XCV_BA];
  assign o_a_oe = q.oe[XCV_BA];

endmodule

// ===== shared/xcv_pkg.sv
package xcv_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // sizes
  localparam int XCV_DATA_W    = 18;
  localparam int XCV_DIRS      = 2;
  localparam int XCV_AB        = 0;
  localparam int XCV_BA        = 1;
  localparam int XCV_BUF_DEPTH = 2;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef logic [XCV_DATA_W-1:0] xcv_word_t;

  // one direction's inputs as sampled from the pins
  typedef struct packed {
    logic      drive;
    logic      transparent;
    logic      capture_clk;
    xcv_word_t data;
  } xcv_pins_s;

  localparam int XCV_PINS_W = $bits(xcv_pins_s);

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam xcv_pins_s XCV_PINS_RST = '0;
  localparam xcv_word_t XCV_WORD_RST = '0;

endpackage

// ===== verilog/xcv_buf.sv
`timescale 1ns/1ps
module xcv_buf #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 2
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_ce,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  import xcv_pkg::*;

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wp;
    logic [PW-1:0]               rp;
    logic [CW-1:0]               count;
  } xcv_buf_s;

  xcv_buf_s q;
  xcv_buf_s next_q;
  logic     push;
  logic     pop;

  ////////////////////////////////////////////////////////////////////////////
  // handshake
  assign o_in_ready  = (q.count != FULL);
  assign o_out_valid = (q.count != '0);
  assign o_out_data  = q.mem[q.rp];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_q = q;
    if (push) begin
      next_q.mem[q.wp] = i_in_data;
      next_q.wp        = (q.wp == LAST) ? '0 : PW'(q.wp + 1'b1);
    end
    if (pop) begin
      next_q.rp = (q.rp == LAST) ? '0 : PW'(q.rp + 1'b1);
    end
    next_q.count = CW'(q.count + CW'(push) - CW'(pop));
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      q <= '0;
    end else if (i_ce) begin
      q <= next_q;
    end
  end

endmodule

// ===== sim/xcv_transceiver_properties.sv
`timescale 1ns/1ps
module xcv_transceiver_properties import xcv_pkg::*; (
  input wire logic      i_sys_clk, i_rst_n, i_ce, i_a_to_b_drive_enable,
  input wire logic      i_a_to_b_transparent_ctl, i_a_to_b_capture_clk,
  input wire logic      i_b_to_a_drive_enable_n, i_b_to_a_transparent_ctl,
  input wire logic      i_b_to_a_capture_clk, o_a_oe, o_b_oe, i_a_accept,
  input wire logic      i_b_accept,
  input wire xcv_word_t i_a, o_a, i_b, o_b
);
  default clocking @(posedge i_sys_clk); endclocking
  // a frozen block answers nothing, so no attempt runs while enable is low
  default disable iff (!i_rst_n || !i_ce);
  ab_on_a: assert property ($rose(i_a_to_b_drive_enable) ##1
    i_a_to_b_drive_enable[*4] |=> o_b_oe) else $error("b not driven");
  ab_off_a: assert property ($fell(i_a_to_b_drive_enable) ##1
    !i_a_to_b_drive_enable[*4] |=> !o_b_oe) else $error("b kept");
  ba_on_a: assert property ($fell(i_b_to_a_drive_enable_n) ##1
    !i_b_to_a_drive_enable_n[*4] |=> o_a_oe) else $error("a not driven");
  ba_off_a: assert property ($rose(i_b_to_a_drive_enable_n) ##1
    i_b_to_a_drive_enable_n[*4] |=> !o_a_oe) else $error("a kept");
  ab_follow_a: assert property ((i_a_to_b_transparent_ctl &&
    i_b_accept && $stable(i_a))[*8] |-> o_b == i_a) else $error("b lags");
  ba_follow_a: assert property ((i_b_to_a_transparent_ctl &&
    i_a_accept && $stable(i_b))[*8] |-> o_a == i_b) else $error("a lags");
  ab_capture_a: assert property (!i_a_to_b_transparent_ctl &&
    $rose(i_a_to_b_capture_clk) && $stable(i_a) ##1 (i_a_to_b_capture_clk
    && !i_a_to_b_transparent_ctl && i_b_accept && $stable(i_a))[*8]
    |-> o_b == i_a) else $error("capture missed");
  ab_hold_a: assert property ((!i_a_to_b_transparent_ctl &&
    i_b_accept && $stable(i_a_to_b_capture_clk))[*8] |=> $stable(o_b))
    else $error("b moved");
endmodule
bind xcv_transceiver xcv_transceiver_properties chk_i (.*);

// ===== sim/xcv_bus_side.sv
`timescale 1ns/1ps
module xcv_bus_side import xcv_pkg::*; (
  input  wire logic      i_sys_clk,
  input  wire logic      i_far_en,
  input  wire xcv_word_t i_far_val,
  input  wire logic      i_dev_oe,
  input  wire xcv_word_t i_dev_val,
  output xcv_word_t      o_level
);
  xcv_word_t last = '0;
  // a released wire flips every cycle instead of keeping its level
  always_comb o_level = i_far_en ? i_far_val
                      : (i_dev_oe === 1'b1) ? i_dev_val : ~last;
  always @(posedge i_sys_clk) last <= o_level;
endmodule

// ===== sim/xcv_transceiver_tb_top.sv
`timescale 1ns/1ps
module xcv_transceiver_tb_top;
  import xcv_pkg::*;
  logic      i_sys_clk = 0, i_rst_n = 0, i_ce = 1, a_en = 1, b_en = 0;
  logic      i_a_to_b_drive_enable = 0, i_a_to_b_transparent_ctl = 0;
  logic      i_a_to_b_capture_clk = 0, i_b_to_a_drive_enable_n = 1;
  logic      i_b_to_a_transparent_ctl = 0, i_b_to_a_capture_clk = 0;
  logic      i_a_accept = 1, i_b_accept = 1, o_a_oe, o_b_oe;
  xcv_word_t v = '0, i_a, i_b, o_a, o_b;
  int        failures = 0, n_tests = 0;
  initial forever #12.5 i_sys_clk = ~i_sys_clk;
  xcv_transceiver dut (.*);
  xcv_bus_side side_a (.i_sys_clk, .i_far_en(a_en), .i_far_val(v),
    .i_dev_oe(o_a_oe), .i_dev_val(o_a), .o_level(i_a));
  xcv_bus_side side_b (.i_sys_clk, .i_far_en(b_en), .i_far_val(v),
    .i_dev_oe(o_b_oe), .i_dev_val(o_b), .o_level(i_b));
  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic chk(input xcv_word_t got, input xcv_word_t exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("failures %0d checks %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic t_ab;
    chk(o_b | o_a | 18'({o_a_oe, o_b_oe}), '0);
    i_a_to_b_drive_enable = 1;
    i_a_to_b_transparent_ctl = 1;
    v = 18'h2aaaa;
    cyc(8);
    chk(i_b, 18'h2aaaa);
    i_a_to_b_drive_enable = 0;
    v = 18'h15554;
    cyc(8);
    chk(o_b | 18'(o_b_oe), 18'h15554);
  endtask
  task automatic t_ba;
    a_en = 0;
    b_en = 1;
    v = 18'h3ffff;
    i_b_to_a_transparent_ctl = 1;
    i_b_to_a_drive_enable_n = 0;
    cyc(8);
    chk(i_a, 18'h3ffff);
    i_b_to_a_drive_enable_n = 1;
    cyc(6);
    chk(18'(o_a_oe), '0);
    a_en = 1;
    b_en = 0;
    i_a_to_b_drive_enable = 1;
  endtask
  task automatic t_latch;
    v = 18'h00abc;
    i_a_to_b_capture_clk = 1;
    cyc(8);
    i_a_to_b_transparent_ctl = 0;
    cyc(1);
    v = 18'h3c3c3;
    cyc(8);
    chk(o_b, 18'h00abc);
    i_a_to_b_capture_clk = 0;
    cyc(8);
    i_a_to_b_capture_clk = 1;
    cyc(10);
    chk(i_b, 18'h3c3c3);
  endtask
  task automatic t_stall;
    i_a_to_b_transparent_ctl = 1;
    i_b_accept = 0;
    for (int k = 1; k < 6; k++) begin
      v = 18'(k);
      cyc(6);
    end
    chk(o_b, 18'h3c3c3);
    i_b_accept = 1;
    cyc(10);
    chk(o_b, 18'h5);
  endtask
  task automatic t_freeze;
    i_ce = 0;
    v = 18'h0f0f0;
    cyc(10);
    chk(o_b, 18'h5);
    chk(18'(o_b_oe), 18'h1);
    i_ce = 1;
    cyc(10);
    chk(o_b, 18'h0f0f0);
  endtask
  initial begin
    cyc(4);
    i_rst_n = 1;
    t_ab;
    t_ba;
    t_latch;
    t_stall;
    t_freeze;
    finish_test;
  end
  initial begin
    #20000;
    failures++;
    finish_test;
  end
endmodule
